// ### hdl/ref_drv_consts.vh
/*
  Constants of the reference input and primary driver register bank:
  register indices, field positions, reset values, driver mode codes.
  Assumes inclusion by bare name from the design files.
*/
`ifndef REF_DRV_CONSTS_VH
`define REF_DRV_CONSTS_VH

// ==========================================================
// register indices (byte address = 4 * index)
`define RX_BG_CTRL_IDX 8'h1a
`define CRYSTAL_INPUT_TUNE_IDX 8'h1b
`define CRYSTAL_INPUT_SPARE_IDX 8'h1c
`define REF_PATH_IDX 8'h1d
`define DRV_CTRL_IDX 8'h32

// ==========================================================
// receiver and band gap control fields
`define RX_RESET_BIT 7
`define BG_TRIM_HI 6
`define BG_TRIM_LO 2
`define BG_OVR_BIT 0
`define RX_BG_RESET 8'h00
`define RX_BG_MASK 8'h7d

// ==========================================================
// crystal tuning fields
`define XT_AUTO_BIT 7
`define XT_CAP_HI 5
`define XT_CAP_LO 0
`define CRYSTAL_INPUT_TUNE_RESET 8'h80
`define CRYSTAL_INPUT_TUNE_MASK 8'hbf
`define XT_CAP_STEP_FF 12'h019
`define XT_CAP_AUTO 6'h00
`define XT_CAP_FF_RESET 12'h627

// ==========================================================
// reference path select fields
`define DOUBLER_BIT 2
`define FORCE_CRYSTAL_INPUT_BIT 0
`define REF_PATH_RESET 8'h00
`define REF_PATH_MASK 8'h05

// ==========================================================
// primary driver control fields
`define DRV_STRONG_BIT 7
`define DRV_PD_BIT 6
`define DRV_MODE_HI 5
`define DRV_MODE_LO 3
`define DRV_POL_HI 2
`define DRV_POL_LO 1
`define DRV_OVR_BIT 0
`define DRV_CTRL_RESET 8'ha8
`define DRV_CTRL_MASK 8'hff

// ==========================================================
// driver mode codes
`define MODE_CMOS_BOTH 3'h0
`define MODE_CMOS_POS 3'h1
`define MODE_CMOS_NEG 3'h2
`define MODE_CMOS_NONE 3'h3
`define MODE_LVDS 3'h4
`define MODE_LVPECL 3'h5

// ==========================================================
// axi responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ### hdl/drive_decode.v
/*
  Primary clock output driver decode: turns the driver control byte and
  the output standard pin into per-pin enables, senses and mode flags.
  Assumes the standard select pin is already synchronised.
*/
`include "ref_drv_consts.vh"
`default_nettype none

module drive_decode (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] drv_ctrl,
  input wire std_sel_sync,
  output reg drv_strong,
  output reg drv_power_down,
  output reg drv_lvds,
  output reg drv_lvpecl,
  output reg drv_cmos,
  output reg pos_enable,
  output reg neg_enable,
  output reg pos_invert,
  output reg neg_invert
);

  // ==========================================================
  // combinational decode
  reg [2:0] mode;
  reg [1:0] pol;
  reg ovr;
  reg cmos_n, lvds_n, pecl_n, pe_n, ne_n, pi_n, ni_n, st_n, pd_n;

  always @* begin
    ovr = drv_ctrl[`DRV_OVR_BIT];
    mode = drv_ctrl[`DRV_MODE_HI:`DRV_MODE_LO];
    pol = drv_ctrl[`DRV_POL_HI:`DRV_POL_LO];
    cmos_n = 1'b0;
    lvds_n = 1'b0;
    pecl_n = 1'b0;
    pe_n = 1'b0;
    ne_n = 1'b0;
    pi_n = 1'b0;
    ni_n = 1'b1;
    // without override the pin picks lvds or lvpecl, strong, powered
    st_n = 1'b1;
    pd_n = 1'b0;
    if (!ovr) begin
      lvds_n = !std_sel_sync;
      pecl_n = std_sel_sync;
      pe_n = 1'b1;
      ne_n = 1'b1;
    end else begin
      st_n = drv_ctrl[`DRV_STRONG_BIT];
      pd_n = drv_ctrl[`DRV_PD_BIT];
      case (mode)
        `MODE_CMOS_BOTH: begin
          cmos_n = 1'b1;
          pe_n = 1'b1;
          ne_n = 1'b1;
        end
        `MODE_CMOS_POS: begin
          cmos_n = 1'b1;
          pe_n = 1'b1;
        end
        `MODE_CMOS_NEG: begin
          cmos_n = 1'b1;
          ne_n = 1'b1;
        end
        `MODE_CMOS_NONE: cmos_n = 1'b1;
        `MODE_LVDS: begin
          lvds_n = 1'b1;
          pe_n = 1'b1;
          ne_n = 1'b1;
        end
        `MODE_LVPECL: begin
          pecl_n = 1'b1;
          pe_n = 1'b1;
          ne_n = 1'b1;
        end
        default: begin
          // unused codes leave the driver idle
        end
      endcase
      // polarity only counts in cmos modes; else default senses
      if (cmos_n) begin
        pi_n = pol[1];
        ni_n = ~pol[0];
      end
    end
    if (pd_n) begin
      pe_n = 1'b0;
      ne_n = 1'b0;
    end
  end

  // ==========================================================
  // registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      drv_strong <= 1'b1;
      drv_power_down <= 1'b0;
      drv_lvds <= 1'b0;
      drv_lvpecl <= 1'b0;
      drv_cmos <= 1'b0;
      pos_enable <= 1'b0;
      neg_enable <= 1'b0;
      pos_invert <= 1'b0;
      neg_invert <= 1'b1;
    end else begin
      drv_strong <= st_n;
      drv_power_down <= pd_n;
      drv_lvds <= lvds_n;
      drv_lvpecl <= pecl_n;
      drv_cmos <= cmos_n;
      pos_enable <= pe_n;
      neg_enable <= ne_n;
      pos_invert <= pi_n;
      neg_invert <= ni_n;
    end
  end

endmodule
`default_nettype wire

// ### hdl/ref_drv_regs.v
/*
  Register bank for the reference input path and the primary clock
  output driver, reached over an AXI4-Lite slave.
  Assumes a single 40 MHz clock and a synchronous active-low reset;
  the standard select pin and the reference-present level are async.
  Only byte lane 0 of a write is stored; each register is one aligned
  word whose upper three bytes read zero. Unmapped or unaligned
  addresses answer with a slave error and change nothing.
  Reads and writes run independently, one of each in flight.
*/
`include "ref_drv_consts.vh"
`default_nettype none

module ref_drv_regs (
  input wire aclk,
  input wire aresetn,
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire output_standard_select_pin,
  input wire ext_ref_present,
  output reg receiver_reset,
  output reg bandgap_manual,
  output reg [4:0] bandgap_trim,
  output reg crystal_input_cap_manual,
  output reg [5:0] crystal_input_cap_code,
  output reg [11:0] crystal_input_cap_ff,
  output reg doubler_enable,
  output reg use_external_ref,
  output wire drv_strong,
  output wire drv_power_down,
  output wire drv_lvds,
  output wire drv_lvpecl,
  output wire drv_cmos,
  output wire pos_enable,
  output wire neg_enable,
  output wire pos_invert,
  output wire neg_invert
);

  // ==========================================================
  // helpers
  // only the low ten address bits decode; higher bits are not wired
  // maps a byte address to a register slot, returns 3'h7 when unmapped
  function [2:0] slot;
    input [9:0] addr;
    begin
      if (addr[1:0] != 2'h0)
        slot = 3'h7;
      else if (addr[9:2] == `RX_BG_CTRL_IDX)
        slot = 3'h0;
      else if (addr[9:2] == `CRYSTAL_INPUT_TUNE_IDX)
        slot = 3'h1;
      else if (addr[9:2] == `CRYSTAL_INPUT_SPARE_IDX)
        slot = 3'h2;
      else if (addr[9:2] == `REF_PATH_IDX)
        slot = 3'h3;
      else if (addr[9:2] == `DRV_CTRL_IDX)
        slot = 3'h4;
      else
        slot = 3'h7;
    end
  endfunction

  // inverted binary tuning code to added capacitance, 0.001 pF units;
  // twelve bits cover the largest value, 63 steps of 25
  function [11:0] cap_ff;
    input [5:0] code;
    reg [5:0] steps;
    begin
      steps = ~code;
      cap_ff = {6'h00, steps} * `XT_CAP_STEP_FF;
    end
  endfunction

  // ==========================================================
  // register storage
  // the spare register has no storage: it reads zero and drops writes
  // writes land on the edge at which bvalid rises
  reg [7:0] rx_bg_reg;
  reg [7:0] crystal_input_tune_reg;
  reg [7:0] ref_path_reg;
  reg [7:0] drv_ctrl_reg;
  reg [7:0] rx_bg_next, crystal_input_tune_next, ref_path_next, drv_ctrl_next;
  reg rx_reset_next;

  // ==========================================================
  // pin synchronisers: first stage feeds only the second
  // both pins are asynchronous to aclk; reset clears them, so the
  // output standard reads as lvds for two cycles after reset
  reg std_meta_reg, std_sync_reg, ref_meta_reg, ref_sync_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      std_meta_reg <= 1'b0;
      std_sync_reg <= 1'b0;
      ref_meta_reg <= 1'b0;
      ref_sync_reg <= 1'b0;
    end else begin
      std_meta_reg <= output_standard_select_pin;
      std_sync_reg <= std_meta_reg;
      ref_meta_reg <= ext_ref_present;
      ref_sync_reg <= ref_meta_reg;
    end
  end

  // ==========================================================
  // write channel: address and data held until both are present
  reg aw_held_reg, w_held_reg;
  reg [9:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;
  wire wr_go;

  // address and data may arrive in either order; the first one waits
  // in its holding register with its ready low until the other comes
  // no new write while the response waits, keeps one write in flight
  assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
  assign wr_go = aw_held_reg && w_held_reg;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 10'h000;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        // an unmapped address is still answered, so the master never hangs
        s_axi_bresp <= (slot(aw_addr_reg) == 3'h7) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // register update; only byte lane 0 carries data
  // a one written to the receiver reset bit is a command, not state
  always @* begin
    rx_bg_next = rx_bg_reg;
    crystal_input_tune_next = crystal_input_tune_reg;
    ref_path_next = ref_path_reg;
    drv_ctrl_next = drv_ctrl_reg;
    rx_reset_next = 1'b0;
    if (wr_go && w_strb_reg[0]) begin
      case (slot(aw_addr_reg))
        3'h0: begin
          rx_bg_next = w_data_reg[7:0] & `RX_BG_MASK;
          rx_reset_next = w_data_reg[`RX_RESET_BIT];
        end
        3'h1: crystal_input_tune_next = w_data_reg[7:0] & `CRYSTAL_INPUT_TUNE_MASK;
        3'h3: ref_path_next = w_data_reg[7:0] & `REF_PATH_MASK;
        3'h4: drv_ctrl_next = w_data_reg[7:0] & `DRV_CTRL_MASK;
        default: begin
          // spare register and unmapped slots store nothing
        end
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_bg_reg <= `RX_BG_RESET;
      crystal_input_tune_reg <= `CRYSTAL_INPUT_TUNE_RESET;
      ref_path_reg <= `REF_PATH_RESET;
      drv_ctrl_reg <= `DRV_CTRL_RESET;
      receiver_reset <= 1'b0;
    end else begin
      rx_bg_reg <= rx_bg_next;
      crystal_input_tune_reg <= crystal_input_tune_next;
      ref_path_reg <= ref_path_next;
      drv_ctrl_reg <= drv_ctrl_next;
      receiver_reset <= rx_reset_next; // one-cycle pulse, self clearing
    end
  end

  // ==========================================================
  // read channel: one read in flight, answer one cycle after address
  // the address is decoded as it is taken, so no address is held
  // and a read never waits on a pending write
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `RESP_OKAY;
      // receiver reset never reads back set: mask keeps bit 7 zero
      case (slot(s_axi_araddr))
        3'h0: s_axi_rdata <= {24'h000000, rx_bg_reg};
        3'h1: s_axi_rdata <= {24'h000000, crystal_input_tune_reg};
        3'h2: s_axi_rdata <= 32'h00000000;
        3'h3: s_axi_rdata <= {24'h000000, ref_path_reg};
        3'h4: s_axi_rdata <= {24'h000000, drv_ctrl_reg};
        default: begin
          // a slave error read returns zero data
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // reference path controls, registered for clean outputs
  // reset values equal the decode of the register defaults, so the
  // outputs never show a state the registers cannot hold
  always @(posedge aclk) begin
    if (!aresetn) begin
      bandgap_manual <= 1'b0;
      bandgap_trim <= 5'h00;
      crystal_input_cap_manual <= 1'b0;
      crystal_input_cap_code <= `XT_CAP_AUTO;
      crystal_input_cap_ff <= `XT_CAP_FF_RESET;
      doubler_enable <= 1'b0;
      use_external_ref <= 1'b0;
    end else begin
      bandgap_manual <= rx_bg_reg[`BG_OVR_BIT];
      bandgap_trim <= rx_bg_reg[`BG_TRIM_HI:`BG_TRIM_LO];
      crystal_input_cap_manual <= !crystal_input_tune_reg[`XT_AUTO_BIT];
      crystal_input_cap_code <= crystal_input_tune_reg[`XT_CAP_HI:`XT_CAP_LO];
      // inverted binary: all ones is zero added, zero is 63 steps
      crystal_input_cap_ff <= cap_ff(crystal_input_tune_reg[`XT_CAP_HI:`XT_CAP_LO]);
      doubler_enable <= ref_path_reg[`DOUBLER_BIT];
      // a lost reference drops the external path three edges later:
      // two synchroniser stages and this register
      use_external_ref <= !ref_path_reg[`FORCE_CRYSTAL_INPUT_BIT] && ref_sync_reg;
    end
  end

  // ==========================================================
  // primary driver decode
  // the decoder registers its outputs, one edge behind the register
  drive_decode u_drive (
    .aclk(aclk),
    .aresetn(aresetn),
    .drv_ctrl(drv_ctrl_reg),
    .std_sel_sync(std_sync_reg),
    .drv_strong(drv_strong),
    .drv_power_down(drv_power_down),
    .drv_lvds(drv_lvds),
    .drv_lvpecl(drv_lvpecl),
    .drv_cmos(drv_cmos),
    .pos_enable(pos_enable),
    .neg_enable(neg_enable),
    .pos_invert(pos_invert),
    .neg_invert(neg_invert)
  );

endmodule
`default_nettype wire

// ### test/ref_drv_chk.sv
/*
  Checker for the reference input and primary driver register bank.
  Assumes it is bound onto ref_drv_regs; one clock, sync active-low reset.
*/
`default_nettype none
module ref_drv_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic ext_ref_present,
  input wire logic receiver_reset,
  input wire logic [5:0] crystal_input_cap_code,
  input wire logic [11:0] crystal_input_cap_ff,
  input wire logic use_external_ref,
  input wire logic drv_power_down,
  input wire logic drv_lvds,
  input wire logic drv_lvpecl,
  input wire logic drv_cmos,
  input wire logic pos_enable,
  input wire logic neg_enable,
  input wire logic pos_invert,
  input wire logic neg_invert
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // properties; a pulse may trail bvalid by one edge
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_rx_single: assert property (receiver_reset |=> !receiver_reset)
    else $error("receiver reset longer than one cycle");
  a_rx_cause: assert property (receiver_reset |-> s_axi_bvalid || $past(s_axi_bvalid))
    else $error("receiver reset without a write");
  a_cap_decode: assert property (crystal_input_cap_ff == {6'h0, ~crystal_input_cap_code} * 12'd25)
    else $error("tuning capacitance decode wrong");
  a_ext_dropped: assert property (!ext_ref_present [*4] |=> !use_external_ref)
    else $error("external path used without a reference");
  a_pd_disables: assert property (drv_power_down |-> !pos_enable && !neg_enable)
    else $error("pin enabled while powered down");
  a_mode_onehot: assert property ($onehot0({drv_lvds, drv_lvpecl, drv_cmos}))
    else $error("more than one driver standard");
  a_unused_mode: assert property (!(drv_lvds || drv_lvpecl || drv_cmos) |->
    !pos_enable && !neg_enable)
    else $error("pins enabled in unused mode");
  a_pol_cmos: assert property (!drv_cmos |-> !pos_invert && neg_invert)
    else $error("polarity applied outside cmos");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
endmodule
`default_nettype wire

// ### test/ref_input_and_output_driver_regs_test.sv
/*
  Bench for the reference input and primary driver register bank.
  Assumes ref_drv_regs, its constants header and a 40 MHz clock.
*/
`include "ref_drv_consts.vh"
`default_nettype none
module ref_input_and_output_driver_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] a_rx = {`RX_BG_CTRL_IDX, 2'b00};
  localparam logic [9:0] a_xt = {`CRYSTAL_INPUT_TUNE_IDX, 2'b00};
  localparam logic [9:0] a_sp = {`CRYSTAL_INPUT_SPARE_IDX, 2'b00};
  localparam logic [9:0] a_rp = {`REF_PATH_IDX, 2'b00};
  localparam logic [9:0] a_dc = {`DRV_CTRL_IDX, 2'b00};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h0, s_axi_araddr = 10'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic output_standard_select_pin = 1'b1, ext_ref_present = 1'b1;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire receiver_reset, bandgap_manual, crystal_input_cap_manual, doubler_enable, use_external_ref;
  wire [4:0] bandgap_trim;
  wire [5:0] crystal_input_cap_code;
  wire [11:0] crystal_input_cap_ff;
  wire drv_strong, drv_power_down, drv_lvds, drv_lvpecl, drv_cmos;
  wire pos_enable, neg_enable, pos_invert, neg_invert;
  wire [8:0] drv_vec;
  int num_errors = 0, samples_checked = 0, rx_pulses = 0;
  logic [31:0] rd;
  logic [1:0] rr;
  logic [7:0] v;

  assign drv_vec = {drv_strong, drv_power_down, drv_lvds, drv_lvpecl, drv_cmos,
                    pos_enable, neg_enable, pos_invert, neg_invert};
  ref_drv_regs dut (.*);
  // 40 MHz clock
  always #12.5 aclk = ~aclk;
  // count receiver reset pulses
  always @(posedge aclk) if (receiver_reset === 1'b1) rx_pulses <= rx_pulses + 1;

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  // both channels offered together; each released when taken
  task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic rd_reg(input logic [9:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
  endtask
  task automatic rchk(input logic [9:0] a, input logic [31:0] e);
    rd_reg(a);
    chk("rdata", e, rd);
    chk("rresp", 32'(`RESP_OKAY), 32'(rr));
  endtask
  // expected driver decode, pin sense as documented
  function automatic logic [8:0] dec(input logic [7:0] x, input logic pin);
    logic [2:0] m;
    logic c, on;
    m = x[5:3];
    c = (m < 3'h4);
    on = !x[6];
    if (!x[0]) return {2'b10, !pin, pin, 1'b0, 2'b11, 2'b01};
    return {x[7], x[6], m == 3'h4, m == 3'h5, c, on && (m < 3'h2 || m[2:1] == 2'b10),
            on && (m == 3'h0 || m == 3'h2 || m[2:1] == 2'b10), c && x[2], !c || !x[1]};
  endfunction
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog, far beyond the expected run
  initial begin
    repeat (20000) @(posedge aclk);
    num_errors++;
    final_report();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("drv", 32'(dec(8'ha8, 1'b1)), 32'(drv_vec));
    chk("ff", 32'h627, 32'(crystal_input_cap_ff));
    chk("ext", 32'h1, 32'(use_external_ref));
    rchk(a_rx, 32'h00);
    rchk(a_xt, 32'h80);
    rchk(a_sp, 32'h00);
    rchk(a_rp, 32'h00);
    rchk(a_dc, 32'ha8);
    // unaligned then unmapped: refused, nothing stored
    wr(a_rx + 10'h1, 32'hff, `RESP_SLVERR);
    wr(10'h3fc, 32'hff, `RESP_SLVERR);
    rd_reg(10'h3fc);
    chk("bad rresp", 32'(`RESP_SLVERR), 32'(rr));
    chk("bad rdata", 32'h0, rd);
    wr(a_rx, 32'hffffffff, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("pulses", 32'h1, 32'(rx_pulses));
    chk("bg", 32'h3f, 32'({bandgap_manual, bandgap_trim}));
    rchk(a_rx, 32'h7d);
    wr(a_xt, 32'hff, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("xt", 32'({1'b0, 6'h3f, 12'h0}), 32'({crystal_input_cap_manual, crystal_input_cap_code, crystal_input_cap_ff}));
    rchk(a_xt, 32'hbf);
    wr(a_xt, 32'h01, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("xt", 32'({1'b1, 6'h01, 12'h60e}), 32'({crystal_input_cap_manual, crystal_input_cap_code, crystal_input_cap_ff}));
    wr(a_sp, 32'hff, `RESP_OKAY);
    rchk(a_sp, 32'h00);
    wr(a_rp, 32'hff, `RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("ref", 32'h2, 32'({doubler_enable, use_external_ref}));
    rchk(a_rp, 32'h05);
    wr(a_rp, 32'h04, `RESP_OKAY);
    repeat (6) @(posedge aclk);
    chk("ref", 32'h3, 32'({doubler_enable, use_external_ref}));
    ext_ref_present <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("ref", 32'h2, 32'({doubler_enable, use_external_ref}));
    // every mode and polarity code under override, then power-down
    for (int i = 0; i < 9; i++) begin
      v = (i == 8) ? 8'hc1 : {i[0], 1'b0, i[2:0], i[1:0], 1'b1};
      wr(a_dc, 32'(v), `RESP_OKAY);
      repeat (4) @(posedge aclk);
      chk("drv", 32'(dec(v, 1'b1)), 32'(drv_vec));
    end
    rchk(a_dc, 32'hc1);
    // without override the pin rules and upper bits are ignored
    wr(a_dc, 32'h40, `RESP_OKAY);
    output_standard_select_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    chk("drv", 32'(dec(8'h40, 1'b0)), 32'(drv_vec));
    output_standard_select_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    chk("drv", 32'(dec(8'h40, 1'b1)), 32'(drv_vec));
    final_report();
  end
endmodule

bind ref_drv_regs ref_drv_chk chk (.*);
`default_nettype wire
